// >>> tpo_consts.vh
// Contract
// [RULE1] when enabled, copy both buffer halves into output latches on selected trigger
// [RULE2] when enabled, pins drive latched bit only where mask selects timed output
// [RULE3] when disabled, all six pins drive zero regardless of mask
// [RULE4] buffer write while disabled passes straight into the matching output latch
// [RULE5] buffer write while enabled reaches latches only at the next trigger
// [RULE6] software disables, sets mask, sets control, loads buffers, then enables
// [RULE7] software loads next value before the selected trigger next occurs
// [RULE8] software loads following values from the trigger event's interrupt handler
// [RULE9] software avoids triggers coinciding with enable changes or enabled buffer writes
// [RULE10] software clears enable before any channel initialization
// [RULE11] after disabling, software reloads both buffers before enabling again
// [RULE12] width zero: halves written independently, trigger select picks each half's source
// [RULE13] width one: write to either address updates both halves, one common trigger
// [RULE14] trigger sources are three compare events chosen by width and select bits
// [RULE15] software changes edge, width and select bits only while disabled
// [RULE16] trigger detected on rising or falling edge per edge-select bit
`ifndef TPO_CONSTS_VH
`define TPO_CONSTS_VH
// register word offsets (byte addresses)
`define TPO_ADDR_LOWER 4'h0
`define TPO_ADDR_UPPER 4'h4
`define TPO_ADDR_MASK 4'h8
`define TPO_ADDR_CTRL 4'hC
// control register field positions
`define TPO_CTRL_ENABLE 7
`define TPO_CTRL_EDGE 6
`define TPO_CTRL_WIDTH 5
`define TPO_CTRL_TRIGSEL 4
// reset values
`define TPO_RESET_BYTE 8'h00
`define TPO_RESET_NIBBLE 4'h0
`define TPO_RESET_MASK 6'h00
`endif

// >>> tpo_edge_detect.v
`timescale 1ns/1ps
module tpo_edge_detect #(
   parameter N = 3
)(
   input wire clk_i,
   input wire rst_i,
   input wire [N-1:0] level_i,
   input wire rising_i,
   output wire [N-1:0] event_o
);
   reg [N-1:0] prev;

   // previous level; reset to zero so a high level after reset counts as a rising edge
   always @(posedge clk_i)
   begin
      if (rst_i)
         prev <= {N{1'b0}};
      else
         prev <= level_i;
   end

   // one-cycle pulse per source on the chosen edge
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1)
      begin : g_edge
         assign event_o[g] = rising_i ? (level_i[g] & ~prev[g]) : (~level_i[g] & prev[g]); // [RULE16]
      end
   endgenerate
endmodule // tpo_edge_detect

// >>> tpo_port.v
`timescale 1ns/1ps
`include "tpo_consts.vh"
module tpo_port (
   input wire clk_i,
   input wire rst_i,
   // classic wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   output reg err_o,
   // timer compare events: [0]=event a, [1]=event b, [2]=event c
   input wire [2:0] compare_event_i,
   output reg [5:0] timed_output_pins_o
);
   ////////////////////////////////////////////////////////////////////////////
   reg [3:0] lower_output_buffer;
   reg [1:0] upper_output_buffer;
   reg [5:0] per_bit_output_mask;
   reg [7:0] channel_control_reg;
   reg [3:0] latch_low;
   reg [1:0] latch_high;
   wire [2:0] edge_event;
   wire channel_output_enable = channel_control_reg[`TPO_CTRL_ENABLE];
   wire trigger_edge_select = channel_control_reg[`TPO_CTRL_EDGE];
   wire width_select_bit = channel_control_reg[`TPO_CTRL_WIDTH];
   wire trigger_select_bit = channel_control_reg[`TPO_CTRL_TRIGSEL];
   wire req = cyc_i & stb_i & ~ack_o & ~err_o;
   wire wr = req & we_i & sel_i[0];
   reg hit;
   reg trig_high;
   reg trig_low;
   // next values of the registered state
   reg [3:0] next_latch_low;
   reg [1:0] next_latch_high;
   reg [5:0] next_pins;
   reg [31:0] next_dat;
   wire wr_low;
   wire wr_high;

   // address decode used by read and write paths alike
   function mapped;
      input [3:0] a;
      begin
         mapped = (a == `TPO_ADDR_LOWER) || (a == `TPO_ADDR_UPPER) ||
                  (a == `TPO_ADDR_MASK) || (a == `TPO_ADDR_CTRL);
      end
   endfunction

   // a buffer write lands in the low half from its own address, or from either one in wide mode
   function lands_low;
      input [3:0] a;
      input wide;
      begin
         lands_low = (a == `TPO_ADDR_LOWER) || (wide && (a == `TPO_ADDR_UPPER));
      end
   endfunction

   // same for the high half; only the pass-through uses it, the buffer registers decode adr_i themselves
   function lands_high;
      input [3:0] a;
      input wide;
      begin
         lands_high = (a == `TPO_ADDR_UPPER) || (wide && (a == `TPO_ADDR_LOWER));
      end
   endfunction

   // buffer write strobes for the disabled pass-through only; the buffer registers decode wr and adr_i on their own
   assign wr_low = wr & lands_low(adr_i, width_select_bit); // [RULE12] [RULE13]
   assign wr_high = wr & lands_high(adr_i, width_select_bit); // [RULE12] [RULE13]

   tpo_edge_detect #(
      .N(3)
   ) u_edge (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(compare_event_i),
      .rising_i(trigger_edge_select),
      .event_o(edge_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // trigger routing: three sources, chosen by width and select bits
   always @*
   begin
      hit = mapped(adr_i);
      if (width_select_bit)
      begin
         trig_high = trigger_select_bit ? edge_event[0] : edge_event[1]; // [RULE13] [RULE14]
         trig_low = trig_high;
      end
      else
      begin
         trig_high = trigger_select_bit ? edge_event[1] : edge_event[2]; // [RULE12] [RULE14]
         trig_low = trigger_select_bit ? edge_event[0] : edge_event[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; both buffer addresses read the combined six bits
   always @*
   begin
      case (adr_i)
         `TPO_ADDR_LOWER, `TPO_ADDR_UPPER:
            next_dat = {26'h000_0000, upper_output_buffer, lower_output_buffer};
         `TPO_ADDR_MASK:
            next_dat = {26'h000_0000, per_bit_output_mask};
         `TPO_ADDR_CTRL:
            next_dat = {24'h00_0000, channel_control_reg[7:4], 4'h0};
         default:
            next_dat = 32'h0000_0000;
      endcase
   end

   // bus handshake: one wait-state ack, err for unmapped addresses; the pending-answer
   // term in req keeps a held request from being taken twice
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= req & hit;
         err_o <= req & ~hit;
         dat_o <= next_dat;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software registers; width mode lets either address load both halves
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lower_output_buffer <= `TPO_RESET_NIBBLE;
         upper_output_buffer <= 2'b00;
         per_bit_output_mask <= `TPO_RESET_MASK;
         channel_control_reg <= `TPO_RESET_BYTE;
      end
      else if (wr)
      begin
         if (adr_i == `TPO_ADDR_LOWER && !width_select_bit)
            lower_output_buffer <= dat_i[3:0]; // [RULE12]
         else if (adr_i == `TPO_ADDR_UPPER && !width_select_bit)
            upper_output_buffer <= dat_i[5:4];
         else if (adr_i == `TPO_ADDR_LOWER || adr_i == `TPO_ADDR_UPPER)
         begin
            lower_output_buffer <= dat_i[3:0]; // [RULE13]
            upper_output_buffer <= dat_i[5:4];
         end
         else if (adr_i == `TPO_ADDR_MASK)
            per_bit_output_mask <= dat_i[5:0];
         else if (adr_i == `TPO_ADDR_CTRL)
            channel_control_reg <= {dat_i[7:4], 4'h0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next latch contents: pass-through writes while disabled, triggered copy while enabled
   always @*
   begin
      next_latch_low = latch_low;
      next_latch_high = latch_high;
      if (!channel_output_enable)
      begin
         // a disabled channel ignores triggers, so a pending edge cannot disturb the preload
         if (wr_low)
            next_latch_low = dat_i[3:0]; // [RULE4]
         if (wr_high)
            next_latch_high = dat_i[5:4]; // [RULE4]
      end
      else
      begin
         // buffer writes do not touch the latches here; a write in the trigger cycle
         // loses to the old buffer value, which is why software keeps the two apart
         if (trig_low)
            next_latch_low = lower_output_buffer; // [RULE1] [RULE5]
         if (trig_high)
            next_latch_high = upper_output_buffer; // [RULE1] [RULE5]
      end
   end

   // output latches
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_low <= `TPO_RESET_NIBBLE;
         latch_high <= 2'h0;
      end
      else
      begin
         latch_low <= next_latch_low;
         latch_high <= next_latch_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin pattern: the enable gates all six bits, the mask gates each one
   always @*
   begin
      if (!channel_output_enable)
         next_pins = 6'h00; // [RULE3]
      else
         next_pins = {latch_high, latch_low} & per_bit_output_mask; // [RULE2]
   end

   // registered pins so they never glitch on mask or enable updates; costs one cycle of latency
   always @(posedge clk_i)
   begin
      if (rst_i)
         timed_output_pins_o <= 6'h00;
      else
         timed_output_pins_o <= next_pins;
   end
endmodule // tpo_port

// >>> tpo_load_model.sv
`timescale 1ns/1ps
// step-driver stand-in: counts each change of the pin pattern
module tpo_load_model (
   input wire clk_i,
   input wire rst_i,
   input wire [5:0] phase_i,
   output logic [7:0] steps_o
);
   logic [5:0] last;
   // a phase change is one motor step
   always @(posedge clk_i)
      if (rst_i) {last, steps_o} <= 14'h0000;
      else if (phase_i != last) {last, steps_o} <= {phase_i, steps_o + 8'h01};
endmodule // tpo_load_model

// >>> tpo_port_sva.sv
`timescale 1ns/1ps
module tpo_port_sva (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire ack_o,
   input wire err_o,
   input wire [2:0] compare_event_i,
   input wire [5:0] timed_output_pins_o
);
   reg en;
   reg [5:0] mask;
   wire req = cyc_i && stb_i && !ack_o && !err_o;
   wire wr = req && we_i && sel_i[0];
   wire [5:0] pins = timed_output_pins_o;
   // shadow enable and mask, taken on the same edge as the port
   always @(posedge clk_i)
      if (rst_i) {en, mask} <= 7'h00;
      else if (wr && adr_i == 4'hC) en <= dat_i[7];
      else if (wr && adr_i == 4'h8) mask <= dat_i[5:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // margins of a few cycles cover the registered pin path
   chk_off_zero: assert property (!en [*3] |-> pins == 6'h00)
      else $error("pins live while off");
   chk_mask_gate: assert property ($stable(mask) [*3] |-> (pins & ~mask) == 6'h00)
      else $error("masked pin driven");
   chk_hold_pins: assert property ((en && $stable(compare_event_i) && $stable(mask)) [*4] |-> $stable(pins))
      else $error("pins moved without trigger");
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   chk_one_answer: assert property (req |=> ack_o != err_o)
      else $error("bad answer");
   chk_err_map: assert property (req && adr_i[1:0] != 2'b00 |=> err_o)
      else $error("no err");
   chk_ack_map: assert property (req && adr_i[1:0] == 2'b00 |=> ack_o)
      else $error("no ack");
   chk_bus_quiet: assert property (!(cyc_i && stb_i) |=> !ack_o && !err_o)
      else $error("stray answer");
endmodule // tpo_port_sva
////////////////////
bind tpo_port tpo_port_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .err_o(err_o),
   .compare_event_i(compare_event_i), .timed_output_pins_o(timed_output_pins_o));

// >>> tb_top.sv
`timescale 1ns/1ps
`include "tpo_consts.vh"
module tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, e;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, q;
   logic [2:0] cmp = 3'h0, cfg, ev;
   logic [5:0] mask, init, nxt, want, pins;
   logic [3:0] sel = 4'hF;
   logic [7:0] s0;
   wire [7:0] steps;
   logic [29:0] rows [8];
   wire [31:0] dat_o;
   wire ack_o, err_o;
   int n_fail = 0, comparisons = 0;
   tpo_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .compare_event_i(cmp),
      .timed_output_pins_o(pins));
   tpo_load_model u_load (.clk_i(clk_i), .rst_i(rst_i), .phase_i(pins), .steps_o(steps));
   // system clock
   initial forever #25 clk_i = ~clk_i;
   task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) $display("[ERR] %s expected %h seen %h", nm, x, g);
      if (g !== x) n_fail++;
   endtask
   // one classic cycle, held until the answer edge; a hang counts as a mismatch
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1 && ++n < 20);
      {q, e} = {dat_o, err_o};
      {cyc_i, stb_i} <= 2'b00;
      if (n >= 20) n_fail++;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog: the run needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      finish_test();
   end
   // rows: {edge,width,select}, mask, first value, next value, toggled events, pins after
   initial
   begin
      rows = '{{3'h4, 6'h3F, 6'h00, 6'h2A, 3'h2, 6'h0A}, {3'h4, 6'h3F, 6'h00, 6'h3F, 3'h4, 6'h30},
         {3'h5, 6'h3F, 6'h00, 6'h3F, 3'h1, 6'h0F}, {3'h5, 6'h3F, 6'h00, 6'h3F, 3'h2, 6'h30},
         {3'h6, 6'h3F, 6'h15, 6'h2A, 3'h2, 6'h2A}, {3'h7, 6'h0F, 6'h00, 6'h3F, 3'h1, 6'h0F},
         {3'h2, 6'h3C, 6'h03, 6'h3F, 3'h2, 6'h3C}, {3'h6, 6'h3F, 6'h15, 6'h2A, 3'h1, 6'h15}};
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, `TPO_ADDR_CTRL, 0);
      check("ctrl reset", 0, q);
      foreach (rows[i])
      begin
         {cfg, mask, init, nxt, ev, want} = rows[i];
         wb(1, `TPO_ADDR_CTRL, 0);
         cmp <= {3{~cfg[2]}};
         wb(1, `TPO_ADDR_MASK, mask);
         wb(1, `TPO_ADDR_CTRL, {1'b0, cfg, 4'h0});
         wb(1, `TPO_ADDR_LOWER, init);
         wb(1, `TPO_ADDR_UPPER, init);
         wb(1, `TPO_ADDR_CTRL, {1'b1, cfg, 4'h0});
         wb(1, `TPO_ADDR_LOWER, nxt);
         wb(1, `TPO_ADDR_UPPER, nxt);
         repeat (3) @(posedge clk_i);
         check("pins held", init & mask, pins);
         s0 = steps;
         cmp <= cmp ^ ev;
         repeat (4) @(posedge clk_i);
         check("pins loaded", want, pins);
         check("load steps", s0 + (want != (init & mask)), steps);
         $display("row %0d done", i);
      end
      wb(0, `TPO_ADDR_LOWER, 0);
      check("buffer read", 32'h0000_002A, q);
      wb(0, `TPO_ADDR_CTRL, 0);
      check("ctrl read", 32'h0000_00E0, q);
      wb(1, 4'h2, 0);
      check("unmapped", 1, e);
      // a write without the low byte lane is acked but must leave the mask alone
      sel <= 4'hE;
      wb(1, `TPO_ADDR_MASK, 0);
      sel <= 4'hF;
      wb(0, `TPO_ADDR_MASK, 0);
      check("lane ignored", 32'h0000_003F, q);
      $display("readback done");
      wb(1, `TPO_ADDR_CTRL, 0);
      repeat (3) @(posedge clk_i);
      check("pins off", 0, pins);
      $display("disable done");
      // mid-run reset with live pins, then the first access after release
      wb(1, `TPO_ADDR_LOWER, 6'h3F);
      wb(1, `TPO_ADDR_UPPER, 6'h3F);
      wb(1, `TPO_ADDR_CTRL, 8'h80);
      repeat (3) @(posedge clk_i);
      check("pins live", 32'h0000_003F, pins);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check("pins in reset", 0, pins);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check("pins after reset", 0, pins);
      wb(0, `TPO_ADDR_LOWER, 0);
      check("buffer after reset", 0, q);
      wb(0, `TPO_ADDR_CTRL, 0);
      check("ctrl after reset", 0, q);
      $display("reset done");
      finish_test();
   end
endmodule // tb_top
